/* File: src/afe_serial_format.sv */
`timescale 1ns/1ps
`default_nettype none

module afe_serial_format
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               serial_clk,
  input  wire logic               serial_data_in,
  input  wire logic               serial_load_strobe,
  input  wire logic               pixel_sync,
  input  wire logic               output_enable_n,
  input  wire logic signed [16:0] sample_level,
  output logic             [7:0]  pixel_out_bus,
  output logic                    pixel_out_oe_n,
  output logic                    pixel_word_valid
);

  logic        [13:0] frame_word;
  logic        [3:0]  frame_count;
  logic        [3:0]  read_gray;
  logic               frame_clear;
  logic               link_rst_n;

  logic               sen_s1;
  logic               sen_s2;
  logic               sen_prev;
  logic               sen_rise;
  logic               ps_s1;
  logic               ps_s2;
  logic               ps_prev;
  logic               ps_rise;
  logic               oe_s1;
  logic               oe_s2;
  logic        [3:0]  rg_s1;
  logic        [3:0]  rg_s2;

  logic        [7:0]  out_cfg;
  logic        [7:0]  read_word;
  logic               read_active;
  logic        [3:0]  read_index;
  logic        [5:0]  frame_addr;
  logic        [7:0]  frame_data;
  logic               frame_full;

  logic        [1:0]  lat_sel;
  logic        [1:0]  fmt_sel;
  logic               invert;
  logic        [1:0]  place;
  logic signed [17:0] offset;
  logic signed [17:0] level_sum;
  logic        [15:0] d1;
  logic        [15:0] d2;
  logic        [15:0] hold_value;
  logic        [3:0]  lat_count;
  logic        [3:0]  lat_target;
  logic               fmt_start;
  logic        [7:0]  fmt_word;
  logic               fmt_valid;

  function automatic logic [3:0] gray_to_bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    b[2] = b[3] ^ g[2];
    b[1] = b[2] ^ g[1];
    b[0] = b[1] ^ g[0];
    return b;
  endfunction

  function automatic logic [3:0] latency_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    return afe_pkg::LATENCY_0;
      2'h1:    return afe_pkg::LATENCY_1;
      2'h2:    return afe_pkg::LATENCY_2;
      default: return afe_pkg::LATENCY_3;
    endcase
  endfunction

  // the link half clears when the core has taken a frame
  assign link_rst_n = resetn & ~frame_clear;

  serial_link_shift u_link
  (
    .serial_clk     (serial_clk),
    .link_rst_n     (link_rst_n),
    .serial_data_in (serial_data_in),
    .frame_word     (frame_word),
    .frame_count    (frame_count),
    .read_gray      (read_gray)
  );

  // pins from outside the core domain
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sen_s1   <= 1'b0;
      sen_s2   <= 1'b0;
      sen_prev <= 1'b0;
      ps_s1    <= 1'b0;
      ps_s2    <= 1'b0;
      ps_prev  <= 1'b0;
      oe_s1    <= 1'b1;
      oe_s2    <= 1'b1;
    end
    else
    begin
      sen_s1   <= serial_load_strobe;
      sen_s2   <= sen_s1;
      sen_prev <= sen_s2;
      ps_s1    <= pixel_sync;
      ps_s2    <= ps_s1;
      ps_prev  <= ps_s2;
      oe_s1    <= output_enable_n;
      oe_s2    <= oe_s1;
    end
  end

  assign sen_rise   = sen_s2 & ~sen_prev;
  assign ps_rise    = ps_s2 & ~ps_prev;

  // serial clock idles around the strobe, so the frame is stable here
  assign frame_addr = frame_word[13:8];
  assign frame_data = frame_word[7:0];
  assign frame_full = frame_count >= afe_pkg::FRAME_FULL;

  // frame decode and control register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_cfg     <= afe_pkg::OUT_CFG_RESET;
      read_word   <= 8'h00;
      frame_clear <= 1'b0;
    end
    else
    begin
      frame_clear <= sen_rise;
      if (sen_rise && frame_full)
      begin
        if (frame_addr[afe_pkg::READ_FLAG_BIT])
        begin
          if ((frame_addr & ~6'h10) == afe_pkg::ADDR_OUT_CFG)
            read_word <= out_cfg;
          else
            read_word <= 8'h00;
        end
        else if (frame_addr == afe_pkg::ADDR_SOFT_RESET)
          out_cfg <= afe_pkg::OUT_CFG_RESET;
        else if (frame_addr == afe_pkg::ADDR_OUT_CFG)
          out_cfg <= frame_data;
      end
    end
  end

  // read-back position, gray coded from the falling-edge counter
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rg_s1 <= 4'h0;
      rg_s2 <= 4'h0;
    end
    else if (sen_rise || frame_clear)
    begin
      rg_s1 <= 4'h0;
      rg_s2 <= 4'h0;
    end
    else
    begin
      rg_s1 <= read_gray;
      rg_s2 <= rg_s1;
    end
  end

  assign read_index = gray_to_bin(rg_s2);

  // a new frame may shift in underneath, only the next strobe restarts it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      read_active <= 1'b0;
    else if (sen_rise && frame_full)
      read_active <= frame_addr[afe_pkg::READ_FLAG_BIT];
    else if (!frame_clear && read_index >= afe_pkg::READ_BITS)
      read_active <= 1'b0;
  end

  // conversion result coding
  assign lat_sel = out_cfg[afe_pkg::LAT_POS +: 2];
  assign fmt_sel = out_cfg[afe_pkg::FMT_POS +: 2];
  assign invert  = out_cfg[afe_pkg::INV_POS];
  assign place   = out_cfg[afe_pkg::PLACE_POS +: 2];

  always_comb
  begin
    case (place)
      afe_pkg::PLACE_TOP:    offset = afe_pkg::OFFSET_TOP;
      afe_pkg::PLACE_BOTTOM: offset = afe_pkg::OFFSET_BOTTOM;
      default:               offset = afe_pkg::OFFSET_MID;
    endcase
  end

  assign level_sum = 18'(sample_level) + offset;

  // out-of-range levels saturate rather than wrap
  always_comb
  begin
    if (level_sum < 18'sh00000)
      d1 = 16'h0000;
    else if (level_sum > 18'sh0FFFF)
      d1 = afe_pkg::FULL_SCALE;
    else
      d1 = level_sum[15:0];
  end

  assign d2 = invert ? (afe_pkg::FULL_SCALE - d1) : d1;

  // latency count runs from the synchronised pixel sync edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_value <= 16'h0000;
      lat_count  <= 4'h0;
      lat_target <= 4'h0;
      fmt_start  <= 1'b0;
    end
    else
    begin
      fmt_start <= 1'b0;
      if (ps_rise)
      begin
        hold_value <= d2;
        lat_target <= latency_cycles(lat_sel);
        lat_count  <= 4'h1;
        fmt_start  <= latency_cycles(lat_sel) == 4'h1;
      end
      else if (lat_count != 4'h0)
      begin
        if (lat_count + 4'h1 == lat_target)
        begin
          fmt_start <= 1'b1;
          lat_count <= 4'h0;
        end
        else
          lat_count <= lat_count + 4'h1;
      end
    end
  end

  pixel_word_sequencer u_seq
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .start       (fmt_start),
    .value       (hold_value),
    .nibble_mode (fmt_sel == afe_pkg::FMT_NIBBLE),
    .word        (fmt_word),
    .word_valid  (fmt_valid)
  );

  // top bit doubles as read-back data while a read is in flight
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pixel_out_bus    <= 8'h00;
      pixel_out_oe_n   <= 1'b1;
      pixel_word_valid <= 1'b0;
    end
    else
    begin
      pixel_out_bus[6:0] <= fmt_word[6:0];
      if (read_active && read_index < afe_pkg::READ_BITS)
        pixel_out_bus[7] <= read_word[3'(4'h7 - read_index)];
      else
        pixel_out_bus[7] <= fmt_word[7];
      pixel_out_oe_n   <= oe_s2;
      pixel_word_valid <= fmt_valid;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_strobe_clears_link: assert property (sen_rise |=> frame_clear)
    else $error("frame not cleared after strobe");

  a_short_frame_dropped: assert property ((sen_rise && !frame_full) |=> $stable(out_cfg))
    else $error("short frame changed a register");

  a_soft_reset_value: assert property (
    (sen_rise && frame_full && frame_addr == afe_pkg::ADDR_SOFT_RESET)
    |=> out_cfg == afe_pkg::OUT_CFG_RESET)
    else $error("soft reset missed");

  a_write_loads_cfg: assert property (
    (sen_rise && frame_full && frame_addr == afe_pkg::ADDR_OUT_CFG)
    |=> out_cfg == $past(frame_data))
    else $error("write not stored");

  a_read_not_write: assert property (
    (sen_rise && frame_full && frame_addr[afe_pkg::READ_FLAG_BIT])
    |=> $stable(out_cfg) && read_active)
    else $error("read request acted as write");

  a_read_msb_first: assert property (
    (sen_rise && frame_full && frame_addr[afe_pkg::READ_FLAG_BIT])
    ##1 (read_index == 4'h0) |=> pixel_out_bus[7] == read_word[7])
    else $error("read-back msb not first");

  a_mid_scale_zero: assert property (
    (ps_rise && sample_level == 17'sh00000 && !place[1] && !invert)
    |=> hold_value == 16'h7FFF)
    else $error("mid-scale code wrong");

  a_invert_result: assert property (
    (ps_rise && invert) |=> hold_value == afe_pkg::FULL_SCALE - $past(d1))
    else $error("inversion wrong");

  a_latency_exact: assert property (
    (ps_rise && lat_sel == 2'h3) |-> !fmt_start[*5] ##1 fmt_start)
    else $error("latency count wrong");

endmodule

`default_nettype wire

/* File: src/afe_pkg.sv */
package afe_pkg;

  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          FRAME_BITS      = 14;
  localparam logic [3:0]  FRAME_FULL      = 4'hE;
  localparam int          READ_FLAG_BIT   = 4;
  localparam logic [3:0]  READ_BITS       = 4'h8;

  // serial register map
  localparam logic [5:0]  ADDR_SOFT_RESET = 6'h04;
  localparam logic [5:0]  ADDR_OUT_CFG    = 6'h06;
  localparam logic [7:0]  OUT_CFG_RESET   = 8'h00;

  // output configuration fields
  localparam int          LAT_POS         = 0;
  localparam int          FMT_POS         = 2;
  localparam int          INV_POS         = 4;
  localparam int          PLACE_POS       = 5;

  // black level placement codes and offsets, nibble format code and full scale
  localparam logic [1:0]  PLACE_TOP       = 2'h2;
  localparam logic [1:0]  PLACE_BOTTOM    = 2'h3;
  localparam logic [1:0]  FMT_NIBBLE      = 2'h3;
  localparam logic [17:0] OFFSET_MID      = 18'h07FFF;
  localparam logic [17:0] OFFSET_TOP      = 18'h0FFFF;
  localparam logic [17:0] OFFSET_BOTTOM   = 18'h00000;
  localparam logic [15:0] FULL_SCALE      = 16'hFFFF;

  // core clock cycles from synchronised pixel sync edge to sequencer start
  localparam logic [3:0]  LATENCY_0       = 4'h2;
  localparam logic [3:0]  LATENCY_1       = 4'h3;
  localparam logic [3:0]  LATENCY_2       = 4'h4;
  localparam logic [3:0]  LATENCY_3       = 4'h5;

  typedef enum logic [0:0] {seq_idle, seq_send} seq_state_type;

endpackage

/* File: src/serial_link_shift.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_link_shift
(
  input  wire logic        serial_clk,
  input  wire logic        link_rst_n,
  input  wire logic        serial_data_in,
  output logic      [13:0] frame_word,
  output logic      [3:0]  frame_count,
  output logic      [3:0]  read_gray
);

  logic [3:0] read_count;
  logic [3:0] next_read_count;

  // one bit per rising edge, msb arrives first
  always_ff @(posedge serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      frame_word  <= 14'h0000;
      frame_count <= 4'h0;
    end
    else
    begin
      frame_word <= {frame_word[12:0], serial_data_in};
      if (frame_count != 4'hF)
        frame_count <= frame_count + 4'h1;
    end
  end

  assign next_read_count = (read_count == afe_pkg::READ_BITS) ? read_count
                                                              : read_count + 4'h1;

  // falling edges step the read-back bit; gray so the core can sample it
  always_ff @(negedge serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      read_count <= 4'h0;
      read_gray  <= 4'h0;
    end
    else
    begin
      read_count <= next_read_count;
      read_gray  <= next_read_count ^ (next_read_count >> 1);
    end
  end

endmodule

`default_nettype wire

/* File: src/pixel_word_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module pixel_word_sequencer
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [15:0] value,
  input  wire logic        nibble_mode,
  output logic      [7:0]  word,
  output logic             word_valid
);

  afe_pkg::seq_state_type state;
  logic [15:0]            held;
  logic [1:0]             index;
  logic                   nibbles;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= afe_pkg::seq_idle;
      held       <= 16'h0000;
      index      <= 2'h0;
      nibbles    <= 1'b0;
      word       <= 8'h00;
      word_valid <= 1'b0;
    end
    else
    begin
      case (state)
        afe_pkg::seq_idle:
        begin
          word_valid <= 1'b0;
          word       <= 8'h00;
          if (start)
          begin
            held       <= value;
            nibbles    <= nibble_mode;
            index      <= 2'h1;
            word_valid <= 1'b1;
            word       <= nibble_mode ? {value[15:12], 4'h0} : value[15:8];
            state      <= afe_pkg::seq_send;
          end
        end
        afe_pkg::seq_send:
        begin
          if (!nibbles)
          begin
            word  <= held[7:0];
            state <= afe_pkg::seq_idle;
          end
          else
          begin
            case (index)
              2'h1:    word <= {held[11:8], 4'h0};
              2'h2:    word <= {held[7:4], 4'h0};
              default: word <= {held[3:0], 4'h0};
            endcase
            index <= index + 2'h1;
            if (index == 2'h3)
              state <= afe_pkg::seq_idle;
          end
        end
        default:
          state <= afe_pkg::seq_idle;
      endcase
    end
  end

  sequence bytes_out(logic [15:0] v);
    (word_valid && word == v[15:8]) ##1 (word_valid && word == v[7:0]);
  endsequence

  sequence nibbles_out(logic [15:0] v);
    (word == {v[15:12], 4'h0}) ##1 (word == {v[11:8], 4'h0})
    ##1 (word == {v[7:4], 4'h0}) ##1 (word == {v[3:0], 4'h0});
  endsequence

  a_byte_order: assert property (@(posedge core_clk) disable iff (!resetn)
    (start && state == afe_pkg::seq_idle && !nibble_mode) |=> bytes_out($past(value)))
    else $error("byte order wrong");

  a_nibble_order: assert property (@(posedge core_clk) disable iff (!resetn)
    (start && state == afe_pkg::seq_idle && nibble_mode) |=> nibbles_out($past(value)))
    else $error("nibble order wrong");

endmodule

`default_nettype wire

/* File: dv/scan_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model
(
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      serial_load_strobe,
  input  wire logic serial_data_out
);
  initial
  begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    serial_load_strobe = 1'b0;
  end

  // sends the top n bits of word, then strobes; rd collects read-back
  task automatic xfer(input logic [13:0] word, input int n, output logic [7:0] rd);
    rd = 8'h00;
    for (int k = 0; k < n; k++)
    begin
      #8 serial_data_in = word[13 - k];
      #24 serial_clk = 1'b1;
      // sampled late in the high phase, read bit stands until the fall
      #31 if (k < 8) rd[7 - k] = serial_data_out;
      #1 serial_clk = 1'b0;
    end
    // released line must not keep showing the last bit
    #8 serial_data_in = ~serial_data_in;
    #32 serial_load_strobe = 1'b1;
    #64 serial_load_strobe = 1'b0;
    #40;
  endtask
endmodule

`default_nettype wire

/* File: dv/afe_serial_format_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define check_eq(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module afe_serial_format_tb;
  logic               core_clk;
  logic               resetn;
  logic               pixel_sync;
  logic               output_enable_n;
  logic signed [16:0] sample_level;
  logic               serial_clk;
  logic               serial_data_in;
  logic               serial_load_strobe;
  logic        [7:0]  pixel_out_bus;
  logic               pixel_out_oe_n;
  logic               pixel_word_valid;
  logic        [7:0]  rd_boot;
  int                 fail_count = 0;
  int                 checked = 0;
  int                 lat_seen[4];

  afe_serial_format i_afe_serial_format
  (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .serial_clk         (serial_clk),
    .serial_data_in     (serial_data_in),
    .serial_load_strobe (serial_load_strobe),
    .pixel_sync         (pixel_sync),
    .output_enable_n    (output_enable_n),
    .sample_level       (sample_level),
    .pixel_out_bus      (pixel_out_bus),
    .pixel_out_oe_n     (pixel_out_oe_n),
    .pixel_word_valid   (pixel_word_valid)
  );

  scan_ctrl_model i_scan_ctrl_model
  (
    .serial_clk         (serial_clk),
    .serial_data_in     (serial_data_in),
    .serial_load_strobe (serial_load_strobe),
    // released pin shows the inverse, so a missing enable reads wrong
    .serial_data_out    (pixel_out_bus[7] ^ pixel_out_oe_n)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  function automatic logic [15:0] expect_word(input logic [7:0] cfg,
                                              input logic signed [16:0] lvl);
    int d;
    d = int'(lvl) + ((cfg[6:5] == 2'h2) ? 65535 : (cfg[6:5] == 2'h3) ? 0 : 32767);
    if (d < 0)
      d = 0;
    if (d > 65535)
      d = 65535;
    if (cfg[4])
      d = 65535 - d;
    return d[15:0];
  endfunction

  task automatic oe_check();
    output_enable_n = 1'b1;
    repeat (6) tick();
    `check_eq("oe_n released", 1'b1, pixel_out_oe_n)
    output_enable_n = 1'b0;
    repeat (6) tick();
    `check_eq("oe_n driven", 1'b0, pixel_out_oe_n)
  endtask

  // each frame collects the read-back of the frame before it
  task automatic serial_check();
    logic [13:0] words[9] = '{14'h0635, 14'h165A, 14'h1600, 14'h0600, 14'h1600,
                              14'h1100, 14'h04FF, 14'h1600, 14'h1600};
    int          nb[9] = '{14, 14, 14, 10, 14, 14, 14, 14, 14};
    logic [8:0]  exp[9] = '{9'h000, 9'h000, 9'h135, 9'h135, 9'h000,
                            9'h135, 9'h100, 9'h000, 9'h100};
    logic [7:0]  rd;
    for (int i = 0; i < 9; i++)
    begin
      i_scan_ctrl_model.xfer(words[i], nb[i], rd);
      if (exp[i][8])
        `check_eq("read-back byte", exp[i][7:0], rd)
    end
  endtask

  task automatic pixel_check();
    logic [7:0]         cfgs[6] = '{8'h00, 8'h35, 8'h6E, 8'h4B, 8'h10, 8'h20};
    logic signed [16:0] lvls[6] = '{17'sh00100, -17'sd16, 17'sh01234, -17'sd256,
                                    17'sh09000, 17'sh00000};
    logic [7:0]         rd;
    logic [15:0]        d;
    int                 n;
    int                 nw;
    for (int i = 0; i < 6; i++)
    begin
      i_scan_ctrl_model.xfer({6'h06, cfgs[i]}, 14, rd);
      sample_level = lvls[i];
      d = expect_word(cfgs[i], lvls[i]);
      tick();
      pixel_sync = 1'b1;
      n = 0;
      while (pixel_word_valid !== 1'b1 && n < 40)
      begin
        tick();
        n++;
        if (n == 2)
          pixel_sync = 1'b0;
      end
      pixel_sync = 1'b0;
      if (n == 40)
      begin
        fail_count++;
        complete_run();
      end
      lat_seen[cfgs[i][1:0]] = n;
      nw = (cfgs[i][3:2] == 2'h3) ? 4 : 2;
      for (int w = 0; w < nw; w++)
      begin
        if (nw == 4)
          `check_eq("nibble word", {d[15 - 4 * w -: 4], 4'h0}, pixel_out_bus)
        else
          `check_eq("byte word", d[15 - 8 * w -: 8], pixel_out_bus)
        `check_eq("word valid", 1'b1, pixel_word_valid)
        tick();
      end
      `check_eq("valid after result", 1'b0, pixel_word_valid)
    end
    // sync timing through the pin synchroniser is fuzzy, so compare steps
    for (int k = 1; k < 4; k++)
      `check_eq("latency step", k, lat_seen[k] - lat_seen[0])
  endtask

  initial
  begin
    resetn = 1'b0;
    pixel_sync = 1'b0;
    output_enable_n = 1'b0;
    sample_level = 17'sh00000;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (2) tick();
    i_scan_ctrl_model.xfer(14'h0400, 14, rd_boot);
    `check_eq("idle read-back", 8'h00, rd_boot)
    oe_check();
    serial_check();
    pixel_check();
    complete_run();
  end
endmodule

`default_nettype wire
